// ### include/timer16_pkg.sv
// Package: register map, field layout, modes and structs of the 16-bit timer
package timer16_pkg;
  localparam logic [11:0] reg_control = 12'h000;
  localparam logic [11:0] reg_status = 12'h004;
  localparam logic [11:0] reg_count = 12'h008;
  localparam logic [11:0] reg_compare_a = 12'h00c;
  localparam logic [11:0] reg_compare_b = 12'h010;
  localparam logic [11:0] reg_capture = 12'h014;
  // Control field positions
  localparam int ctl_mode_lsb = 0;
  localparam int ctl_act_a_lsb = 4;
  localparam int ctl_act_b_lsb = 6;
  localparam int ctl_clk_sel_lsb = 8;
  localparam int ctl_dir_a_bit = 11;
  localparam int ctl_dir_b_bit = 12;
  localparam int ctl_port_a_bit = 13;
  localparam int ctl_port_b_bit = 14;
  // Status field positions, write one to clear
  localparam int st_ovf_bit = 0;
  localparam int st_cmp_a_bit = 1;
  localparam int st_cmp_b_bit = 2;
  localparam int st_cap_bit = 3;
  localparam logic [31:0] control_reset = 32'h0000_0000;
  localparam logic [15:0] count_reset = 16'h0000;
  localparam logic [15:0] count_max = 16'hffff;
  localparam logic [15:0] count_bottom = 16'h0000;
  localparam logic [15:0] top_8bit = 16'h00ff;
  localparam logic [15:0] top_9bit = 16'h01ff;
  localparam logic [15:0] top_10bit = 16'h03ff;
  localparam logic [3:0] mode_ctc_cmp = 4'h4;
  localparam logic [3:0] mode_fast_8 = 4'h5;
  localparam logic [3:0] mode_fast_9 = 4'h6;
  localparam logic [3:0] mode_fast_10 = 4'h7;
  localparam logic [3:0] mode_ctc_cap = 4'hc;
  localparam logic [3:0] mode_fast_cap = 4'he;
  localparam logic [3:0] mode_fast_cmp = 4'hf;
  localparam logic [1:0] act_none = 2'h0;
  localparam logic [1:0] act_toggle = 2'h1;
  localparam logic [1:0] act_clear = 2'h2;
  localparam logic [1:0] act_set = 2'h3;
  // Prescale divisors
  localparam int div_1 = 1;
  localparam int div_8 = 8;
  localparam int div_64 = 64;
  localparam int div_256 = 256;
  localparam int div_1024 = 1024;
  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;

  typedef enum logic [1:0] {
    bus_idle = 2'b01,
    bus_resp = 2'b10
  } bus_state_t;

  typedef struct packed {
    logic tick;
    logic top_hit;
    logic max_hit;
    logic cmp_a_hit;
    logic cmp_b_hit;
  } timer_events_t;
endpackage

// ### src/timer16_prescaler.sv
// Prescaler: one-cycle tick at aclk divided by 1, 8, 64, 256 or 1024
`timescale 1ns/1ps
module timer16_prescaler
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] clk_sel,
  output logic tick
);
  import timer16_pkg::*;

  logic [9:0] div_count;
  logic hit;

  always_comb
  begin
    case (clk_sel)
      3'h1: hit = 1'b1;
      3'h2: hit = (div_count[2:0] == 3'h7);
      3'h3: hit = (div_count[5:0] == 6'h3f);
      3'h4: hit = (div_count[7:0] == 8'hff);
      3'h5: hit = (div_count == 10'h3ff);
      default: hit = 1'b0;
    endcase
  end

  // Free running so switching divisors needs no resync
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      div_count <= 10'h000;
    else
      div_count <= div_count + 10'h001;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tick <= 1'b0;
    else
      tick <= hit;
  end
endmodule // timer16_prescaler

// ### src/timer16_ctc_fast_pwm.sv
// Timer16: counter, clear-on-compare and fast PWM logic with AXI4-Lite
`timescale 1ns/1ps
module timer16_ctc_fast_pwm
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic pin_a_out,
  output logic pin_a_oe_n,
  output logic pin_b_out,
  output logic pin_b_oe_n
);
  import timer16_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i +: 8] = val[8*i +: 8];
    return r;
  endfunction

  // Mask compare value to the fixed resolution of the mode
  function automatic logic [15:0] mask_fixed(input logic [3:0] mode,
                                             input logic [15:0] val);
    case (mode)
      mode_fast_8: return val & top_8bit;
      mode_fast_9: return val & top_9bit;
      mode_fast_10: return val & top_10bit;
      default: return val;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] control;
  logic [15:0] count_value;
  logic [15:0] compare_a_value;
  logic [15:0] compare_a_buf;
  logic [15:0] compare_b_value;
  logic [15:0] compare_b_buf;
  logic [15:0] capture_value;
  logic overflow_flag;
  logic compare_a_flag;
  logic compare_b_flag;
  logic capture_flag;
  logic wave_out_a;
  logic wave_out_b;
  logic block_match;
  bus_state_t wr_state;
  bus_state_t rd_state;
  logic [11:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic wr_fire;
  logic [31:0] wr_word;
  logic [31:0] rd_word;
  logic rd_ok;
  logic [3:0] waveform_mode_sel;
  logic [1:0] output_action_a;
  logic [1:0] output_action_b;
  logic pin_direction_a;
  logic pin_direction_b;
  logic fast_pwm;
  logic ctc;
  logic [15:0] top;
  logic top_from_a;
  logic top_from_cap;
  logic at_top;
  timer_events_t ev;
  logic count_wr;
  logic [15:0] next_count;

  assign waveform_mode_sel = control[ctl_mode_lsb +: 4];
  assign output_action_a = control[ctl_act_a_lsb +: 2];
  assign output_action_b = control[ctl_act_b_lsb +: 2];
  assign pin_direction_a = control[ctl_dir_a_bit];
  assign pin_direction_b = control[ctl_dir_b_bit];

  timer16_prescaler u_prescaler
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_sel(control[ctl_clk_sel_lsb +: 3]),
    .tick(ev.tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode and top selection
  always_comb
  begin
    fast_pwm = 1'b0;
    ctc = 1'b0;
    top = count_max;
    top_from_a = 1'b0;
    top_from_cap = 1'b0;
    case (waveform_mode_sel)
      mode_ctc_cmp:
      begin
        ctc = 1'b1;
        top = compare_a_value;
        top_from_a = 1'b1;
      end
      mode_ctc_cap:
      begin
        ctc = 1'b1;
        top = capture_value;
        top_from_cap = 1'b1;
      end
      mode_fast_8:
      begin
        fast_pwm = 1'b1;
        top = top_8bit;
      end
      mode_fast_9:
      begin
        fast_pwm = 1'b1;
        top = top_9bit;
      end
      mode_fast_10:
      begin
        fast_pwm = 1'b1;
        top = top_10bit;
      end
      mode_fast_cap:
      begin
        fast_pwm = 1'b1;
        top = capture_value;
        top_from_cap = 1'b1;
      end
      mode_fast_cmp:
      begin
        fast_pwm = 1'b1;
        top = compare_a_value;
        top_from_a = 1'b1;
      end
      default: top = count_max;
    endcase
  end

  // Exact equality only: a top below count is missed until the wrap
  assign at_top = (count_value == top);
  // A register-defined top is a compare match, so a count write blocks it
  assign ev.top_hit = ev.tick && at_top && (ctc || fast_pwm) &&
    !(block_match && (top_from_a || top_from_cap));
  assign ev.max_hit = ev.tick && (count_value == count_max);
  assign ev.cmp_a_hit = ev.tick && !block_match &&
    (count_value == compare_a_value);
  assign ev.cmp_b_hit = ev.tick && !block_match &&
    (count_value == compare_b_value);

  always_comb
  begin
    if (ev.top_hit)
      next_count = count_bottom;
    else
      next_count = count_value + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path: address and data taken in either order
  assign wr_fire = aw_held && w_held && wr_state == bus_idle;
  assign count_wr = wr_fire && aw_addr == reg_count;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
      s_axi_awready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held && !s_axi_awready;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[11:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      else if (wr_fire)
        aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_wready <= !w_held && !s_axi_wready;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      else if (wr_fire)
        w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_state <= bus_idle;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= resp_okay;
    end
    else
    begin
      case (wr_state)
        bus_idle:
          if (wr_fire)
          begin
            wr_state <= bus_resp;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr <= reg_capture) ? resp_okay : resp_slverr;
          end
        bus_resp:
          if (s_axi_bready)
          begin
            wr_state <= bus_idle;
            s_axi_bvalid <= 1'b0;
          end
        default: wr_state <= bus_idle;
      endcase
    end
  end

  always_comb
  begin
    case (aw_addr)
      reg_control: wr_word = merge(control, w_data, w_strb);
      reg_count: wr_word = merge({16'h0000, count_value}, w_data, w_strb);
      reg_compare_a:
        wr_word = merge({16'h0000, compare_a_buf}, w_data, w_strb);
      reg_compare_b:
        wr_word = merge({16'h0000, compare_b_buf}, w_data, w_strb);
      reg_capture:
        wr_word = merge({16'h0000, capture_value}, w_data, w_strb);
      default: wr_word = merge(32'h0000_0000, w_data, w_strb);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      control <= control_reset;
    else if (wr_fire && aw_addr == reg_control)
      control <= {17'h00000, wr_word[14:0]};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      capture_value <= count_reset;
    else if (wr_fire && aw_addr == reg_capture)
      capture_value <= wr_word[15:0];
  end

  // Counter, with one-tick match blocking after a software write
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_value <= count_reset;
      block_match <= 1'b0;
    end
    else if (count_wr)
    begin
      count_value <= wr_word[15:0];
      block_match <= 1'b1;
    end
    else if (ev.tick)
    begin
      count_value <= next_count;
      block_match <= 1'b0;
    end
  end

  // Compare buffers: direct in clear-on-compare, reload at top in fast PWM
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      compare_a_buf <= count_reset;
      compare_b_buf <= count_reset;
      compare_a_value <= count_reset;
      compare_b_value <= count_reset;
    end
    else
    begin
      if (wr_fire && aw_addr == reg_compare_a)
        compare_a_buf <= mask_fixed(waveform_mode_sel,
          wr_word[15:0]);
      if (wr_fire && aw_addr == reg_compare_b)
        compare_b_buf <= mask_fixed(waveform_mode_sel,
          wr_word[15:0]);
      if (!fast_pwm)
      begin
        compare_a_value <= compare_a_buf;
        compare_b_value <= compare_b_buf;
      end
      else if (ev.top_hit)
      begin
        compare_a_value <= compare_a_buf;
        compare_b_value <= compare_b_buf;
      end
    end
  end

  // Flags: hardware set wins over a same-cycle software clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      overflow_flag <= 1'b0;
      compare_a_flag <= 1'b0;
      compare_b_flag <= 1'b0;
      capture_flag <= 1'b0;
    end
    else
    begin
      if (wr_fire && aw_addr == reg_status)
      begin
        if (wr_word[st_ovf_bit])
          overflow_flag <= 1'b0;
        if (wr_word[st_cmp_a_bit])
          compare_a_flag <= 1'b0;
        if (wr_word[st_cmp_b_bit])
          compare_b_flag <= 1'b0;
        if (wr_word[st_cap_bit])
          capture_flag <= 1'b0;
      end
      if ((fast_pwm && ev.top_hit) || (!fast_pwm && ev.max_hit))
        overflow_flag <= 1'b1;
      if (ev.cmp_a_hit || (ev.top_hit && top_from_a))
        compare_a_flag <= 1'b1;
      if (ev.cmp_b_hit)
        compare_b_flag <= 1'b1;
      if (ev.top_hit && top_from_cap)
        capture_flag <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Waveform state; action bits take effect immediately
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wave_out_a <= 1'b0;
      wave_out_b <= 1'b0;
    end
    else
    begin
      // Match first, bottom after: compare at top then yields a steady level for clear and set actions
      if (ev.cmp_a_hit)
      begin
        case (output_action_a)
          act_toggle: wave_out_a <= !wave_out_a;
          act_clear: wave_out_a <= 1'b0;
          act_set: wave_out_a <= 1'b1;
          default: wave_out_a <= wave_out_a;
        endcase
      end
      if (fast_pwm && ev.top_hit && output_action_a[1])
        wave_out_a <= !output_action_a[0];
      if (ev.cmp_b_hit && output_action_b[1])
        wave_out_b <= output_action_b[0];
      else if (ev.cmp_b_hit && output_action_b == act_toggle && !fast_pwm)
        wave_out_b <= !wave_out_b;
      if (fast_pwm && ev.top_hit && output_action_b[1])
        wave_out_b <= !output_action_b[0];
    end
  end

  // Pins: output enable low while driven
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_a_out <= 1'b0;
      pin_a_oe_n <= 1'b1;
      pin_b_out <= 1'b0;
      pin_b_oe_n <= 1'b1;
    end
    else
    begin
      pin_a_oe_n <= !pin_direction_a;
      pin_a_out <= (output_action_a == act_none) ?
        control[ctl_port_a_bit] : wave_out_a;
      pin_b_oe_n <= !pin_direction_b;
      pin_b_out <= (output_action_b == act_none) ?
        control[ctl_port_b_bit] : wave_out_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path, one word at a time
  always_comb
  begin
    rd_ok = 1'b1;
    case ({s_axi_araddr[11:2], 2'b00})
      reg_control: rd_word = control;
      reg_status: rd_word = {28'h0000000, capture_flag, compare_b_flag,
        compare_a_flag, overflow_flag};
      reg_count: rd_word = {16'h0000, count_value};
      reg_compare_a: rd_word = {16'h0000, compare_a_buf};
      reg_compare_b: rd_word = {16'h0000, compare_b_buf};
      reg_capture: rd_word = {16'h0000, capture_value};
      default:
      begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_state <= bus_idle;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= resp_okay;
    end
    else
    begin
      case (rd_state)
        bus_idle:
        begin
          s_axi_arready <= !s_axi_arready;
          if (s_axi_arvalid && s_axi_arready)
          begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? resp_okay : resp_slverr;
            rd_state <= bus_resp;
          end
        end
        bus_resp:
          if (s_axi_rready)
          begin
            s_axi_rvalid <= 1'b0;
            rd_state <= bus_idle;
          end
        default: rd_state <= bus_idle;
      endcase
    end
  end
endmodule // timer16_ctc_fast_pwm

// ### bench/timer16_ctc_fast_pwm_sva.sv
// Checker: bus handshake and pin assertions at the timer ports
`timescale 1ns/1ps
module timer16_ctc_fast_pwm_sva
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pin_a_out,
  input wire logic pin_a_oe_n
);
  import timer16_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////
  // Released pin must not float to a stale level after reset
  a_reset_pins: assert property (
    $rose(aresetn) |-> pin_a_oe_n && !pin_a_out && !s_axi_bvalid)
    else $error("pin or response not cleared by reset");
  a_bvalid_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before taken");
  a_bvalid_drop: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before taken");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_refused: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] > reg_capture[11:2]
    |=> s_axi_rresp == resp_slverr && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_read_okay: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] <= reg_capture[11:2]
    |=> s_axi_rresp == resp_okay)
    else $error("mapped read refused");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
  a_write_refused: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_awaddr[11:2] > reg_capture[11:2]
    |-> ##[1:8] (s_axi_bvalid && s_axi_bresp == resp_slverr))
    else $error("unmapped write not refused");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_refused: cover property (s_axi_rvalid && s_axi_rresp == resp_slverr);
  c_wave: cover property ($rose(pin_a_out));
endmodule // timer16_ctc_fast_pwm_sva

bind timer16_ctc_fast_pwm timer16_ctc_fast_pwm_sva
  timer16_ctc_fast_pwm_sva_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .pin_a_out(pin_a_out), .pin_a_oe_n(pin_a_oe_n)
);

// ### bench/timer16_pin_load.sv
// Partner: port pin with an external pull-down load
`timescale 1ns/1ps
module timer16_pin_load
(
  input wire logic pin_out,
  input wire logic pin_oe_n,
  output logic pin_level
);
  // Released pin falls to the pull-down, never holds the last level
  assign pin_level = pin_oe_n ? 1'b0 : pin_out;
endmodule // timer16_pin_load

// ### bench/tb_timer16_ctc_fast_pwm.sv
// Testbench: register accesses and pin waveform counts for the timer
`timescale 1ns/1ps
module tb_timer16_ctc_fast_pwm;
  import timer16_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pa_out, pa_oe_n, pa_lvl;
  logic pb_out, pb_oe_n;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] mk;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;
  int dv [5] = '{div_1, div_8, div_64, div_256, div_1024};
  logic [3:0] tm [3] = '{mode_ctc_cmp, mode_ctc_cap, mode_fast_cmp};
  logic [15:0] tops [3] = '{top_8bit, top_9bit, top_10bit};
  ////////////////////////////////////////////////////////////////////////////
  timer16_ctc_fast_pwm timer16_ctc_fast_pwm_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_a_out(pa_out),
    .pin_a_oe_n(pa_oe_n), .pin_b_out(pb_out), .pin_b_oe_n(pb_oe_n)
  );
  timer16_pin_load timer16_pin_load_inst (
    .pin_out(pa_out), .pin_oe_n(pa_oe_n), .pin_level(pa_lvl)
  );
  always #20 aclk = ~aclk;
  // Longest path is the slowest prescale run, about 31k cycles; the whole test stays under 50k
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      bad_count++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task summarize;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [31:0] ctl(input logic [3:0] m,
    input logic [1:0] a, input logic [2:0] s, input logic [1:0] dp);
    ctl = 32'h0000_0000;
    ctl[ctl_mode_lsb +: 4] = m;
    ctl[ctl_act_a_lsb +: 2] = a;
    ctl[ctl_clk_sel_lsb +: 3] = s;
    ctl[ctl_dir_a_bit] = dp[0];
    ctl[ctl_port_a_bit] = dp[1];
  endfunction
  // Entered just after an edge; ends one edge after the response
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1)
      @(posedge aclk);
    bready <= 1'b0;
    chk("bresp", {30'h0, bresp}, {30'h0, er});
    @(posedge aclk);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
      @(posedge aclk);
    while (arready !== 1'b1);
    arvalid <= 1'b0;
    do
      @(posedge aclk);
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rdata", rdata, exp);
    chk("rresp", {30'h0, rresp}, {30'h0, er});
    @(posedge aclk);
  endtask
  // Timer stopped while reprogrammed so no stray match lands mid-setup
  task pwm(input logic [3:0] m, input logic [1:0] a, input logic [2:0] s,
    input logic [15:0] top, input logic [15:0] cmp, input logic [1:0] dp,
    input int settle);
    wr(reg_control, ctl(m, a, 3'h0, dp), resp_okay);
    wr(reg_capture, {16'h0000, top}, resp_okay);
    wr(reg_compare_a, {16'h0000, cmp}, resp_okay);
    wr(reg_count, 32'h0000_0000, resp_okay);
    wr(reg_control, ctl(m, a, s, dp), resp_okay);
    repeat (settle) @(posedge aclk);
  endtask
  // Window is whole periods, so the count does not depend on phase
  task meas(input int n, input int exp);
    int hi;
    hi = 0;
    repeat (n)
    begin
      @(negedge aclk);
      if (pa_lvl === 1'b1)
        hi++;
    end
    @(posedge aclk);
    chk("high cycles", 32'(hi), 32'(exp));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(reg_control, control_reset, resp_okay);
    rd(reg_count, {16'h0000, count_reset}, resp_okay);
    rd(reg_status, 32'h0000_0000, resp_okay);
    wr(12'h020, 32'h0000_0001, resp_slverr);
    rd(12'h020, 32'h0000_0000, resp_slverr);
    pwm(mode_fast_cap, act_clear, 3'h1, 16'h0009, 16'h0003, 2'h1,
      40);
    meas(100, 40);
    pwm(mode_fast_cap, act_set, 3'h1, 16'h0009, 16'h0003, 2'h1, 40);
    meas(100, 60);
    pwm(mode_fast_cap, act_clear, 3'h1, 16'h0009, 16'h0000, 2'h1, 40);
    meas(100, 10);
    pwm(mode_fast_cap, act_clear, 3'h1, 16'h0009, 16'h0009, 2'h1, 40);
    meas(100, 100);
    wr(reg_control, ctl(mode_fast_cap, act_clear, 3'h0, 2'h1), resp_okay);
    rd(reg_status, 32'h0000_000f, resp_okay);
    repeat (50) @(posedge aclk);
    wr(reg_status, 32'h0000_0001, resp_okay);
    rd(reg_status, 32'h0000_000e, resp_okay);
    foreach (tm[i])
    begin
      pwm(tm[i], act_toggle, 3'h1, 16'h0004, 16'h0004, 2'h1, 40);
      meas(100, 50);
    end
    for (int i = 0; i < 3; i++)
    begin
      mk = 16'h053f & tops[i];
      pwm(4'(mode_fast_8 + i), act_clear, 3'h1, 16'h0009, 16'h053f, 2'h1,
        1100);
      rd(reg_compare_a, {16'h0000, mk}, resp_okay);
      meas(int'(tops[i]) + 1, int'(mk) + 1);
    end
    for (int s = 1; s <= 5; s++)
    begin
      pwm(mode_fast_cap, act_clear, 3'(s), 16'h0009, 16'h0003, 2'h1,
        20 * dv[s - 1]);
      meas(10 * dv[s - 1], 4 * dv[s - 1]);
    end
    pwm(mode_fast_cap, act_none, 3'h1, 16'h0009, 16'h0003, 2'h3, 40);
    meas(100, 100);
    pwm(mode_fast_cap, act_clear, 3'h1, 16'h0009, 16'h0003, 2'h0, 40);
    meas(100, 0);
    chk("pin enable", {31'h0, pa_oe_n}, 32'h0000_0001);
    chk("pin b", {30'h0, pb_out, pb_oe_n}, 32'h0000_0001);
    wr(reg_control, ctl(mode_ctc_cmp, act_toggle, 3'h0, 2'h1), resp_okay);
    wr(reg_compare_a, 32'h0000_0004, resp_okay);
    wr(reg_count, 32'h0000_fff0, resp_okay);
    wr(reg_status, 32'h0000_000f, resp_okay);
    wr(reg_control, ctl(mode_ctc_cmp, act_toggle, 3'h1, 2'h1), resp_okay);
    repeat (40) @(posedge aclk);
    wr(reg_control, ctl(mode_ctc_cmp, act_toggle, 3'h0, 2'h1), resp_okay);
    rd(reg_status, 32'h0000_0007, resp_okay);
    // Count written equal to compare A; slow ticks stop it short of top
    wr(reg_control, ctl(mode_ctc_cap, act_toggle, 3'h0, 2'h1), resp_okay);
    wr(reg_capture, 32'h0000_0009, resp_okay);
    wr(reg_compare_a, 32'h0000_0005, resp_okay);
    wr(reg_count, 32'h0000_0005, resp_okay);
    wr(reg_status, 32'h0000_000f, resp_okay);
    wr(reg_control, ctl(mode_ctc_cap, act_toggle, 3'h2, 2'h1), resp_okay);
    repeat (10) @(posedge aclk);
    wr(reg_control, ctl(mode_ctc_cap, act_toggle, 3'h0, 2'h1), resp_okay);
    rd(reg_status, 32'h0000_0000, resp_okay);
    summarize();
  end
endmodule // tb_timer16_ctc_fast_pwm
